// file: hdl/sarrd_top.sv
// Conversion control of an 18-bit SAR converter with serial readout.
// Function
// - A convert_start rising edge after acquisition has finished starts a conversion.
// - Result ready no earlier than 1.0 us and no later than 2.08 us after start.
// - Each sample resolves to an 18-bit unsigned code by successive approximation.
// - Conversion plus acquisition fit a 2.5 us period, 400 kSPS.
// - Bits decided one at a time from MSB down, comparator settled each step.
// - An internal step clock times the conversion; no serial clock needed.
// - After the last decision: back to acquisition, code latched, busy signalled.
// - Between conversions the converter rests in standby.
// - Straight binary code, midscale 0x20000, zero input gives zero code.
// - Input below ground yields the all-zero code.
// - Input above the reference range yields the full-scale code.
// - Chip-select mode: low convert_start or SDI enables SDO, top bit first.
// - Chip-select mode: SDO released when both go high or after the last bit.
// - SDO moves to the next bit on each SCK falling edge, holding briefly.
// - Chip-select mode: SDI sampled at the convert_start rising edge.
// - Chain mode: SCK level sampled at the convert_start rising edge.
// - Chain mode: SDI from upstream captured on each SCK falling edge.
// - Chain mode with busy: SDO goes high soon after SDI goes high.
// - SDI high at start selects chip-select mode, low selects chain mode.
// - Start bit added when select low at end, or chain SCK high at start.
// - Three-wire without busy: SDO released after 18th fall or start rise.
module sarrd_top
    import sarrd_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // Serial host pins
    input  wire logic              convert_start,
    input  wire logic              sck,
    input  wire logic              sdi,
    output logic                   sdo,
    output logic                   sdo_oe,
    // Analog front end
    input  wire logic              comp_high,
    input  wire logic              over_range,
    input  wire logic              under_range,
    output logic [RES_W-1:0]       dac_code,
    output logic                   sample_on,
    output logic                   standby,
    output logic                   converting
);

    // ==========================================================
    // Pin synchronisers
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;

    assign pin_raw[PIN_CNV] = convert_start;
    assign pin_raw[PIN_SCK] = sck;
    assign pin_raw[PIN_SDI] = sdi;
    assign pin_raw[PIN_CMP] = comp_high;
    assign pin_raw[PIN_OVR] = over_range;
    assign pin_raw[PIN_UND] = under_range;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    wire cnv_s = sync2[PIN_CNV];
    wire sck_s = sync2[PIN_SCK];
    wire sdi_s = sync2[PIN_SDI];
    wire cmp_s = sync2[PIN_CMP];
    wire ovr_s = sync2[PIN_OVR];
    wire und_s = sync2[PIN_UND];

    // ==========================================================
    // Edge detection on the synchronised pins
    logic cnv_d;
    logic sck_d;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnv_d <= 1'b0;
            sck_d <= 1'b0;
        end else begin
            cnv_d <= cnv_s;
            sck_d <= sck_s;
        end
    end

    wire cnv_rise = cnv_s & ~cnv_d;
    wire sck_fall = sck_d & ~sck_s;

    // ==========================================================
    // Conversion state and counters
    localparam logic [6:0] CONV_MIN_LAST = 7'(CONV_MIN_CYC - 1);
    localparam logic [6:0] CONV_MAX_LAST = 7'(CONV_MAX_CYC - 1);
    localparam logic [4:0] ACQ_LAST      = 5'(ACQ_CYC - 1);
    localparam logic [1:0] SETTLE_LAST   = 2'(SETTLE_CYC - 1);
    localparam logic [4:0] BIT_LAST      = 5'(RES_W - 1);

    sarrd_state_t state;
    sarrd_state_t next_state;
    logic [6:0]   conv_cnt;
    logic [4:0]   acq_cnt;
    logic [1:0]   step_cnt;
    logic [4:0]   bit_idx;
    logic         bits_done;
    logic         mode_cs;
    logic         chain_busy;
    logic         clamp_hi;
    logic         clamp_lo;

    sarrd_stream_if #(.WIDTH(WORD_W)) to_fifo ();
    sarrd_stream_if #(.WIDTH(WORD_W)) from_fifo ();

    // Start accepted only from standby: acquisition must have run out
    wire start_ok    = cnv_rise & (state == ST_STANDBY);
    wire acq_done    = (acq_cnt == '0);
    wire step_end    = (state == ST_CONV) & ~bits_done & (step_cnt == SETTLE_LAST);
    wire last_bit    = (bit_idx == BIT_LAST);
    wire min_elapsed = (conv_cnt >= CONV_MIN_LAST);
    wire conv_phase  = (state == ST_CONV) | (state == ST_DONE);

    // Trial weight halves each step, starting at half the reference
    wire [RES_W-1:0] trial_mask = CODE_MIDSCALE >> bit_idx;
    wire [RES_W-1:0] kept_code  = cmp_s ? dac_code : (dac_code & ~trial_mask);
    wire [RES_W-1:0] step_code  = kept_code | (trial_mask >> 1);

    // Over-range forces full scale, under-range forces zero
    wire [RES_W-1:0] final_code = clamp_hi ? CODE_FULL :
                                  clamp_lo ? CODE_ZERO :
                                  dac_code;

    // Start bit decided when the conversion ends in chip-select mode, at the start edge in chain mode
    wire cs_select  = ~cnv_s | ~sdi_s;
    wire has_start  = mode_cs ? cs_select : chain_busy;
    wire start_val  = ~mode_cs;

    assign to_fifo.valid = (state == ST_DONE);
    assign to_fifo.data  = {has_start, start_val, final_code};

    always_comb begin
        next_state = state;
        unique case (state)
            ST_ACQ: begin
                if (acq_done) begin
                    next_state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (start_ok) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (bits_done & min_elapsed) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (to_fifo.ready) begin
                    next_state = ST_ACQ;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= ST_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    // Elapsed time since start, saturating at the longest conversion
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            conv_cnt <= '0;
        end else if (start_ok) begin
            conv_cnt <= '0;
        end else if (conv_phase & (conv_cnt != CONV_MAX_LAST)) begin
            conv_cnt <= conv_cnt + 7'h01;
        end
    end

    // Acquisition window before standby
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            acq_cnt <= '0;
        end else if ((state == ST_DONE) & to_fifo.ready) begin
            acq_cnt <= ACQ_LAST;
        end else if ((state == ST_ACQ) & ~acq_done) begin
            acq_cnt <= acq_cnt - 5'h01;
        end
    end

    // Internal step clock: one decision every SETTLE_CYC cycles
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            step_cnt <= '0;
        end else if (start_ok) begin
            step_cnt <= '0;
        end else if (state == ST_CONV) begin
            step_cnt <= step_cnt + 2'h1;
        end
    end

    // Bit walk from MSB to LSB
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bit_idx   <= '0;
            bits_done <= 1'b0;
            dac_code  <= CODE_ZERO;
        end else if (start_ok) begin
            bit_idx   <= '0;
            bits_done <= 1'b0;
            dac_code  <= CODE_MIDSCALE;
        end else if (step_end) begin
            dac_code  <= step_code;
            bits_done <= last_bit;
            if (!last_bit) begin
                bit_idx <= bit_idx + 5'h01;
            end
        end
    end

    // Mode, busy option and range flags caught at the start edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_cs    <= 1'b1;
            chain_busy <= 1'b0;
            clamp_hi   <= 1'b0;
            clamp_lo   <= 1'b0;
        end else if (start_ok) begin
            mode_cs    <= sdi_s;
            chain_busy <= ~sdi_s & sck_s;
            clamp_hi   <= ovr_s;
            clamp_lo   <= und_s;
        end
    end

    // ==========================================================
    // Result queue
    sarrd_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .fill    (to_fifo.snk),
        .drain   (from_fifo.src)
    );

    // ==========================================================
    // Serial shifter
    logic [RES_W:0] shreg;
    logic [4:0]     bits_left;
    logic           loaded;

    wire             q_start = from_fifo.data[RES_W+1];
    wire             q_val   = from_fifo.data[RES_W];
    wire [RES_W-1:0] q_code  = from_fifo.data[RES_W-1:0];

    // A new start discards the word still being read
    wire load_now  = ~loaded & from_fifo.valid & ~start_ok;
    wire cs_shift  = mode_cs & cs_select;
    wire shift_now = loaded & sck_fall & (cs_shift | ~mode_cs);
    wire shift_in  = ~mode_cs & sdi_s;
    wire word_end  = shift_now & (bits_left == 5'h01);

    wire [RES_W:0] load_word = q_start ? {q_val, q_code}
                                       : {q_code, 1'b0};
    wire [4:0]     load_bits = q_start ? BITS_STARTED : BITS_PLAIN;

    assign from_fifo.ready = load_now;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            loaded    <= 1'b0;
            bits_left <= '0;
            shreg     <= '0;
        end else if (start_ok | word_end) begin
            loaded    <= 1'b0;
            bits_left <= '0;
        end else if (load_now) begin
            loaded    <= 1'b1;
            bits_left <= load_bits;
            shreg     <= load_word;
        end else if (shift_now) begin
            bits_left <= bits_left - 5'h01;
            shreg     <= {shreg[RES_W-1:0], shift_in};
        end
    end

    // ==========================================================
    // Pin outputs
    // SDO is high impedance while converting in chip-select mode
    wire cs_drive   = loaded & cs_select & ~conv_phase;
    wire next_oe    = mode_cs ? cs_drive : 1'b1;
    wire chain_idle = ~mode_cs & chain_busy & sdi_s;
    wire next_sdo   = loaded ? shreg[RES_W] : chain_idle;

    // Registered outputs keep the old bit for a cycle past each fall
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sdo        <= 1'b0;
            sdo_oe     <= 1'b0;
            sample_on  <= 1'b1;
            standby    <= 1'b1;
            converting <= 1'b0;
        end else begin
            sdo        <= next_sdo;
            sdo_oe     <= next_oe;
            sample_on  <= (next_state == ST_ACQ) | (next_state == ST_STANDBY);
            standby    <= (next_state == ST_STANDBY);
            converting <= (next_state == ST_CONV) | (next_state == ST_DONE);
        end
    end

endmodule : sarrd_top

// file: hdl/sarrd_pkg.sv
// Shared constants of the SAR converter control and serial readout.
package sarrd_pkg;

    // ==========================================================
    // Result format
    localparam int           RES_W          = 18;
    localparam logic [17:0]  CODE_ZERO      = 18'h0_0000;
    localparam logic [17:0]  CODE_MIDSCALE  = 18'h2_0000;
    localparam logic [17:0]  CODE_MID_LESS  = 18'h1_FFFF;
    localparam logic [17:0]  CODE_FULL      = 18'h3_FFFF;
    localparam int           WORD_W         = RES_W + 2;
    localparam int           FIFO_DEPTH     = 4;

    // ==========================================================
    // Serial word lengths
    localparam logic [4:0]   BITS_PLAIN     = 5'h12;
    localparam logic [4:0]   BITS_STARTED   = 5'h13;

    // ==========================================================
    // Timing in nanoseconds and derived cycle counts
    localparam int           CLK_NS         = 25;
    localparam int           CONV_MIN_NS    = 1000;
    localparam int           CONV_MAX_NS    = 2080;
    localparam int           ACQ_NS         = 420;
    localparam int           CONV_MIN_CYC   = (CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int           CONV_MAX_CYC   = CONV_MAX_NS / CLK_NS;
    localparam int           ACQ_CYC        = (ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int           SETTLE_CYC     = 4;

    // ==========================================================
    // Synchronised pin indices
    localparam int           PIN_CNV        = 0;
    localparam int           PIN_SCK        = 1;
    localparam int           PIN_SDI        = 2;
    localparam int           PIN_CMP        = 3;
    localparam int           PIN_OVR        = 4;
    localparam int           PIN_UND        = 5;
    localparam int           PIN_N          = 6;

    // ==========================================================
    // Control states
    typedef enum logic [1:0] {
        ST_ACQ,
        ST_STANDBY,
        ST_CONV,
        ST_DONE
    } sarrd_state_t;

endpackage : sarrd_pkg

// file: hdl/sarrd_stream_if.sv
// Valid/ready word stream between the converter core and its queue.
interface sarrd_stream_if #(parameter int WIDTH = 20);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sarrd_stream_if

// file: hdl/sarrd_fifo.sv
// Small result queue with valid/ready on both sides.
module sarrd_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // Filling side
    sarrd_stream_if.snk     fill,
    // Draining side
    sarrd_stream_if.src     drain
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;

    wire push = fill.valid & fill.ready;
    wire pop  = drain.valid & drain.ready;

    assign fill.ready  = (count != (AW+1)'(DEPTH));
    assign drain.valid = (count != '0);
    assign drain.data  = mem[rd_ptr];
    assign next_count  = count + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= fill.data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
        end
    end

endmodule : sarrd_fifo

// file: bench/sarrd_afe_model.sv
// Behavioural analog front end: comparator against a held input level.
module sarrd_afe_model
    import sarrd_pkg::*;
(
    // Held input and trial code
    input  wire logic [RES_W-1:0] level,
    input  wire logic [RES_W-1:0] dac_code,
    // Comparator decision
    output logic                  comp_high
);
    timeunit 1ns;
    timeprecision 100ps;
    // Input at or above the trial keeps the trial bit
    assign comp_high = (level >= dac_code);
endmodule : sarrd_afe_model

// file: bench/sarrd_top_props.sv
// Concurrent checks on the converter control and readout pins.
module sarrd_top_props
    import sarrd_pkg::*;
(
    // Clock and reset
    input wire logic             clk_sys,
    input wire logic             sys_rst,
    // Serial host pins
    input wire logic             convert_start,
    input wire logic             sck,
    input wire logic             sdi,
    input wire logic             sdo,
    input wire logic             sdo_oe,
    // Analog front end
    input wire logic             comp_high,
    input wire logic             over_range,
    input wire logic             under_range,
    input wire logic [RES_W-1:0] dac_code,
    input wire logic             sample_on,
    input wire logic             standby,
    input wire logic             converting
);
    localparam int MIN_RUN = CONV_MIN_CYC - 4;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Helper counters
    logic [7:0] conv_cnt;
    logic [3:0] fall_age;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            conv_cnt <= 8'h00;
            fall_age <= 4'hF;
        end else begin
            conv_cnt <= converting ? conv_cnt + 8'h01 : 8'h00;
            fall_age <= $fell(sck) ? 4'h0 : (fall_age == 4'hF ? fall_age : fall_age + 4'h1);
        end
    end

    // ==========================================================
    // Properties
    sequence s_acq;
        ##[0:2] (sample_on && !standby);
    endsequence
    sequence s_rest;
        ##[12:22] standby;
    endsequence
    property p_start;
        $rose(convert_start) && standby && !converting |-> ##[2:6] converting;
    endproperty
    property p_min_run;
        $fell(converting) |-> conv_cnt >= MIN_RUN;
    endproperty
    property p_msb_trial;
        $rose(converting) |-> ##[0:2] (dac_code == CODE_MIDSCALE);
    endproperty
    property p_step;
        converting && $changed(dac_code) |=> $stable(dac_code) [*3];
    endproperty
    property p_quiet;
        converting && $past(converting) |-> !sample_on && !standby;
    endproperty
    property p_back;
        $fell(converting) |-> s_acq ##0 s_rest;
    endproperty
    property p_rest;
        standby |-> sample_on;
    endproperty
    property p_release;
        $rose(convert_start) && sdi |-> ##[1:5] !sdo_oe;
    endproperty
    property p_shift;
        // Chain idle output follows sdi, so only shifts under a settled select are judged
        !convert_start && sdi && sdo_oe && $past(sdo_oe) && $past(sdo_oe, 2) && $changed(sdo)
            && $past(sdi, 2) && $past(sdi, 3) && $past(sdi, 4)
            |-> fall_age inside {[1:5]};
    endproperty
    property p_reset;
        disable iff (1'b0) sys_rst |=> !converting && !sdo_oe && standby && sample_on;
    endproperty

    a_start: assert property (p_start)
        else $error("start edge in standby began no conversion");
    a_min_run: assert property (p_min_run)
        else $error("conversion ended too early");
    a_msb_trial: assert property (p_msb_trial)
        else $error("first trial is not the midscale code");
    a_step: assert property (p_step)
        else $error("trial code changed faster than one step");
    a_quiet: assert property (p_quiet)
        else $error("sampling or standby during conversion");
    a_back: assert property (p_back)
        else $error("no acquisition then standby after conversion");
    a_rest: assert property (p_rest)
        else $error("standby without input switches on");
    a_release: assert property (p_release)
        else $error("output not released after select rose");
    a_shift: assert property (p_shift)
        else $error("output bit moved without a clock fall");
    a_reset: assert property (p_reset)
        else $error("outputs not idle under reset");
endmodule : sarrd_top_props

// file: bench/tb_sarrd_top.sv
// Self-checking bench of the converter control and serial readout.
module tb_sarrd_top
    import sarrd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic             clk_sys       = 1'b0;
    logic             sys_rst       = 1'b1;
    logic             convert_start = 1'b0;
    logic             sck           = 1'b0;
    logic             sdi           = 1'b1;
    logic             over_range    = 1'b0;
    logic             under_range   = 1'b0;
    logic [RES_W-1:0] level         = 18'h0_0000;
    logic [RES_W-1:0] dac_code;
    logic             sdo;
    logic             sdo_oe;
    logic             comp_high;
    logic             sample_on;
    logic             standby;
    logic             converting;
    int               err_total     = 0;
    int               checks_done   = 0;
    int               seed          = 16;
    logic [19:0]      exp_q[$];
    int               len_q[$];
    logic [RES_W-1:0] bnd[4]        = '{CODE_MIDSCALE, CODE_MID_LESS, CODE_ZERO, CODE_FULL};

    always #12.5 clk_sys = ~clk_sys;

    sarrd_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .convert_start(convert_start),
        .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .comp_high(comp_high),
        .over_range(over_range), .under_range(under_range), .dac_code(dac_code),
        .sample_on(sample_on), .standby(standby), .converting(converting));
    sarrd_afe_model u_afe (.level(level), .dac_code(dac_code), .comp_high(comp_high));

    // ==========================================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic guard(input int n);
        if (n >= 300) begin
            err_total++;
            $display("unexpected at %0t: wait ran out, got %h expected %h", $time, n, 300);
            conclude();
        end
    endtask : guard

    // Start one conversion and queue the word the host should read
    task automatic conv(input bit cs, input bit busy, input bit ovr, input bit und,
                        input logic [RES_W-1:0] lvl, input bit extra);
        int          n;
        logic [19:0] w;
        n = 0;
        while (standby !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        guard(n);
        sdi         <= cs;
        sck         <= !cs && busy;
        over_range  <= ovr;
        under_range <= und;
        level       <= lvl;
        tick(2);
        convert_start <= 1'b1;
        tick(6);
        sck <= 1'b0;
        if (cs && busy) convert_start <= 1'b0;
        if (extra) begin
            tick(4);
            convert_start <= 1'b0;
            tick(4);
            convert_start <= 1'b1;
        end
        n = extra ? 14 : 6;
        while (converting !== 1'b0 && n < 300) begin
            tick(1);
            n++;
        end
        guard(n);
        chk({19'h0_0000, n >= CONV_MIN_CYC && n <= CONV_MAX_CYC + 1}, 20'h0_0001);
        w = {2'b00, ovr ? CODE_FULL : (und ? CODE_ZERO : lvl)};
        if (busy && !cs) w[18] = 1'b1;
        exp_q.push_back(w);
        len_q.push_back(18 + int'(busy));
    endtask : conv

    // Clock one word out and compare it bit by bit
    task automatic rd(input bit cs);
        logic [19:0] w;
        int          len;
        w   = exp_q.pop_front();
        len = len_q.pop_front();
        convert_start <= 1'b0;
        tick(5);
        if (cs) chk({19'h0_0000, sdo_oe}, 20'h0_0001);
        for (int i = len - 1; i >= 0; i--) begin
            sck <= 1'b1;
            tick(2);
            chk({19'h0_0000, sdo}, {19'h0_0000, w[i]});
            tick(2);
            sck <= 1'b0;
            tick(4);
        end
        tick(2);
        if (cs) chk({19'h0_0000, sdo_oe}, 20'h0_0000);
        else chk({19'h0_0000, sdo}, 20'h0_0000);
    endtask : rd

    // ==========================================================
    // Main sequence
    initial begin
        logic [RES_W-1:0] lvl;
        tick(6);
        sys_rst <= 1'b0;
        tick(3);
        for (int i = 0; i < 12; i++) begin
            lvl = RES_W'($random(seed));
            if (i < 4) lvl = bnd[i];
            conv(i % 4 < 2, i % 2 == 1, i == 5 || i == 7, i == 6 || i == 7, lvl, i == 4);
            rd(i % 4 < 2);
            if (i % 4 == 3) begin
                sdi <= 1'b1;
                tick(6);
                chk({19'h0_0000, sdo}, 20'h0_0001);
                sdi <= 1'b0;
                tick(2);
            end
            $display("test %0d done", i);
        end
        // Reset in the middle of a conversion
        sdi <= 1'b1;
        tick(2);
        convert_start <= 1'b1;
        tick(20);
        sys_rst <= 1'b1;
        tick(3);
        sys_rst       <= 1'b0;
        convert_start <= 1'b0;
        tick(1);
        chk({16'h0000, converting, standby, sdo_oe, sample_on}, 20'h0_0005);
        conv(1'b1, 1'b0, 1'b0, 1'b0, CODE_MID_LESS, 1'b0);
        rd(1'b1);
        $display("test reset recovery done");
        conclude();
    end
endmodule : tb_sarrd_top

bind sarrd_top sarrd_top_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .convert_start(convert_start), .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .comp_high(comp_high), .over_range(over_range), .under_range(under_range),
    .dac_code(dac_code), .sample_on(sample_on), .standby(standby), .converting(converting));
